// *** stia_defines.svh ***
// Offsets, field positions and reset values of the switch table access block.
// Assumes a 12-bit AXI4-Lite byte address and 32-bit data words.
`ifndef STIA_DEFINES_SVH
`define STIA_DEFINES_SVH
`define STIA_V_E0_OFS 12'h400
`define STIA_V_E1_OFS 12'h404
`define STIA_V_E2_OFS 12'h408
`define STIA_V_IDX_OFS 12'h40C
`define STIA_V_CTRL_OFS 12'h410
`define STIA_SA_CTRL_OFS 12'h41C
`define STIA_MC_DATA_OFS 12'h424
`define STIA_KEY_HI_OFS 12'h428
`define STIA_KEY_LO_OFS 12'h42C
`define STIA_MC_ENTRIES 7'h30
`define STIA_MC_RES_LSB 30
`define STIA_GROUP_ID_LSB 16
`define STIA_SA_SEL_BIT 8
`define STIA_SA_RD_BIT 9
`define STIA_SA_GO_BIT 15
`define STIA_V0_VALID_BIT 16
`define STIA_V0_FOPT_BIT 15
`define STIA_V0_PRIO_LSB 12
`define STIA_V0_MSTI_LSB 8
`define STIA_V_START_BIT 7
`define STIA_V_RD_BIT 0
`define STIA_RESP_OKAY 2'h0
`define STIA_RESP_SLVERR 2'h2
`define STIA_RESET_WORD 32'h00000000
`endif

// *** stia_pkg.sv ***
// Types shared by the switch table access block.
// Assumes stia_defines.svh is on the include path.
package stia_pkg;
    typedef enum logic [1:0] {STIA_IDLE, STIA_ACCESS, STIA_LOAD} stia_op_t;

    // One VLAN table entry; port fields hold ports 3..1
    typedef struct packed {
        logic valid;
        logic fwd_option;
        logic [2:0] priority_v;
        logic [2:0] spanning_tree_instance;
        logic [6:0] filter_group_id;
        logic [2:0] untag;
        logic [2:0] members;
    } stia_vlan_entry_t;

    // Full key of one static entry
    typedef struct packed {
        logic [6:0] filter_group_id;
        logic [15:0] mac_hi;
        logic [31:0] mac_lo;
    } stia_static_key_t;

    // All register and handshake state of the block
    typedef struct packed {
        logic aw_held;
        logic [11:0] aw_addr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [1:0] mc_res;
        logic [2:0] mc_fwd;
        stia_static_key_t key;
        logic [5:0] sa_idx;
        logic sa_sel;
        logic sa_rd;
        logic sa_go;
        stia_op_t sa_op;
        stia_vlan_entry_t ve;
        logic [11:0] v_idx;
        logic v_rd;
        logic v_start;
        stia_op_t v_op;
    } stia_state_t;
endpackage

// *** stia_switch_table_indirect_access.sv ***
// Indirect software access to the static key, reserved multicast and VLAN
// tables, plus the read ports the lookup engine uses.
// Assumes an AXI4-Lite master on aclk and lookup inputs from aclk logic.
`timescale 1ns/1ps
`default_nettype none
`include "stia_defines.svh"
module stia_switch_table_indirect_access (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic vlan_mode_en,
    input wire logic [11:0] vlan_lookup_id,
    output stia_pkg::stia_vlan_entry_t vlan_lookup_entry,
    output logic vlan_lookup_hit,
    output logic vlan_use_members,
    input wire logic [5:0] mc_lookup_addr,
    output logic [2:0] mc_lookup_ports,
    input wire logic [3:0] static_lookup_idx,
    output stia_pkg::stia_static_key_t static_lookup_key
);
    import stia_pkg::*;

    stia_state_t st;
    stia_state_t next_st;
    stia_static_key_t static_mem [16];
    logic [2:0] mc_mem [8];
    stia_vlan_entry_t vlan_mem [4096];
    stia_static_key_t static_rdq;
    logic [2:0] mc_rdq;
    stia_vlan_entry_t vlan_rdq;
    logic lk_en_q;
    logic static_we;
    logic mc_we;
    logic vlan_we;
    logic [31:0] wm;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;
    logic sa_busy;
    logic v_busy;
    logic [31:0] key_hi_word;
    logic [31:0] v_idx_word;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Fixed group of a reserved multicast index, six addresses per group
    function automatic logic [2:0] mc_group(input logic [5:0] idx);
        logic [5:0] q;
        q = idx / 6'h06;
        return q[2:0];
    endfunction

    // Only the first 48 multicast indices exist
    function automatic logic mc_exists(input logic [5:0] idx);
        return {1'b0, idx} < `STIA_MC_ENTRIES;
    endfunction

    // Handshake outputs and registered answers
    assign awready = !st.aw_held && !st.bvalid;
    assign wready = !st.w_held && !st.bvalid;
    assign arready = !st.rvalid;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;
    assign sa_busy = st.sa_go;
    assign v_busy = st.v_start;
    assign wm = merge(`STIA_RESET_WORD, st.wdata, st.wstrb);

    // Stored words merged with the pending write, for fields that span byte lanes
    assign key_hi_word = merge({9'h000, st.key.filter_group_id, st.key.mac_hi}, st.wdata,
                               st.wstrb);
    assign v_idx_word = merge({20'h00000, st.v_idx}, st.wdata, st.wstrb);

    // Register read view
    always_comb begin
        rd_resp = `STIA_RESP_OKAY;
        case (araddr & 12'hFFC)
            `STIA_MC_DATA_OFS: rd_word = {st.mc_res, 27'h0000000, st.mc_fwd};
            `STIA_KEY_HI_OFS: rd_word = {9'h000, st.key.filter_group_id, st.key.mac_hi};
            `STIA_KEY_LO_OFS: rd_word = st.key.mac_lo;
            `STIA_SA_CTRL_OFS: rd_word = {16'h0000, st.sa_go, 5'h00, st.sa_rd, st.sa_sel,
                                          2'h0, st.sa_idx};
            `STIA_V_E0_OFS: rd_word = {15'h0000, st.ve.valid, st.ve.fwd_option,
                                       st.ve.priority_v, 1'b0, st.ve.spanning_tree_instance,
                                       1'b0, st.ve.filter_group_id};
            `STIA_V_E1_OFS: rd_word = {29'h00000000, st.ve.untag};
            `STIA_V_E2_OFS: rd_word = {29'h00000000, st.ve.members};
            `STIA_V_IDX_OFS: rd_word = {20'h00000, st.v_idx};
            `STIA_V_CTRL_OFS: rd_word = {24'h000000, st.v_start, 6'h00, st.v_rd};
            default: begin
                rd_word = `STIA_RESET_WORD;
                rd_resp = `STIA_RESP_SLVERR;
            end
        endcase
    end

    // Bus slave, staging registers and both access sequencers
    always_comb begin
        next_st = st;
        static_we = 1'b0;
        mc_we = 1'b0;
        vlan_we = 1'b0;
        if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        if (awvalid && awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = awaddr & 12'hFFC;
        end
        if (wvalid && wready) begin
            next_st.w_held = 1'b1;
            next_st.wdata = wdata;
            next_st.wstrb = wstrb;
        end
        // Write takes effect once address and data are both held
        if (st.aw_held && st.w_held) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `STIA_RESP_OKAY;
            case (st.aw_addr)
                `STIA_MC_DATA_OFS: begin
                    if (!sa_busy) begin
                        if (st.wstrb[3]) begin
                            next_st.mc_res = wm[`STIA_MC_RES_LSB +: 2];
                        end
                        if (st.wstrb[0]) begin
                            next_st.mc_fwd = wm[2:0];
                        end
                    end
                end
                `STIA_KEY_HI_OFS: begin
                    if (!sa_busy) begin
                        next_st.key.filter_group_id = key_hi_word[`STIA_GROUP_ID_LSB +: 7];
                        next_st.key.mac_hi = key_hi_word[15:0];
                    end
                end
                `STIA_KEY_LO_OFS: begin
                    if (!sa_busy) begin
                        next_st.key.mac_lo = merge(st.key.mac_lo, st.wdata, st.wstrb);
                    end
                end
                `STIA_SA_CTRL_OFS: begin
                    if (!sa_busy) begin
                        if (st.wstrb[0]) begin
                            next_st.sa_idx = wm[5:0];
                        end
                        if (st.wstrb[1]) begin
                            next_st.sa_sel = wm[`STIA_SA_SEL_BIT];
                            next_st.sa_rd = wm[`STIA_SA_RD_BIT];
                            next_st.sa_go = wm[`STIA_SA_GO_BIT];
                        end
                    end
                end
                `STIA_V_E0_OFS: begin
                    if (!v_busy) begin
                        if (st.wstrb[0]) begin
                            next_st.ve.filter_group_id = wm[6:0];
                        end
                        if (st.wstrb[1]) begin
                            next_st.ve.spanning_tree_instance = wm[`STIA_V0_MSTI_LSB +: 3];
                            next_st.ve.priority_v = wm[`STIA_V0_PRIO_LSB +: 3];
                            next_st.ve.fwd_option = wm[`STIA_V0_FOPT_BIT];
                        end
                        if (st.wstrb[2]) begin
                            next_st.ve.valid = wm[`STIA_V0_VALID_BIT];
                        end
                    end
                end
                `STIA_V_E1_OFS: begin
                    if (!v_busy && st.wstrb[0]) begin
                        next_st.ve.untag = wm[2:0];
                    end
                end
                `STIA_V_E2_OFS: begin
                    if (!v_busy && st.wstrb[0]) begin
                        next_st.ve.members = wm[2:0];
                    end
                end
                `STIA_V_IDX_OFS: begin
                    if (!v_busy) begin
                        next_st.v_idx = v_idx_word[11:0];
                    end
                end
                `STIA_V_CTRL_OFS: begin
                    if (!v_busy && st.wstrb[0]) begin
                        next_st.v_rd = wm[`STIA_V_RD_BIT];
                        next_st.v_start = wm[`STIA_V_START_BIT];
                    end
                end
                default: next_st.bresp = `STIA_RESP_SLVERR;
            endcase
        end
        // Read channel, one outstanding answer
        if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_word;
            next_st.rresp = rd_resp;
        end
        // Static and multicast sequencer
        case (st.sa_op)
            STIA_IDLE: begin
                if (st.sa_go) begin
                    next_st.sa_op = STIA_ACCESS;
                end
            end
            STIA_ACCESS: begin
                if (st.sa_rd) begin
                    next_st.sa_op = STIA_LOAD;
                end else begin
                    static_we = !st.sa_sel;
                    mc_we = st.sa_sel && mc_exists(st.sa_idx);
                    next_st.sa_go = 1'b0;
                    next_st.sa_op = STIA_IDLE;
                end
            end
            STIA_LOAD: begin
                if (st.sa_sel) begin
                    next_st.mc_fwd = mc_exists(st.sa_idx) ? mc_rdq : 3'h0;
                end else begin
                    next_st.key = static_rdq;
                end
                next_st.sa_go = 1'b0;
                next_st.sa_op = STIA_IDLE;
            end
            default: next_st.sa_op = STIA_IDLE;
        endcase
        // VLAN sequencer
        case (st.v_op)
            STIA_IDLE: begin
                if (st.v_start) begin
                    next_st.v_op = STIA_ACCESS;
                end
            end
            STIA_ACCESS: begin
                if (st.v_rd) begin
                    next_st.v_op = STIA_LOAD;
                end else begin
                    vlan_we = 1'b1;
                    next_st.v_start = 1'b0;
                    next_st.v_op = STIA_IDLE;
                end
            end
            STIA_LOAD: begin
                next_st.ve = vlan_rdq;
                next_st.v_start = 1'b0;
                next_st.v_op = STIA_IDLE;
            end
            default: next_st.v_op = STIA_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Static and multicast memories; static entries never age
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 16; i++) begin
                static_mem[i] <= '0;
            end
            for (int i = 0; i < 8; i++) begin
                mc_mem[i] <= 3'h0;
            end
            static_rdq <= '0;
            mc_rdq <= 3'h0;
            mc_lookup_ports <= 3'h0;
            static_lookup_key <= '0;
        end else begin
            if (static_we) begin
                static_mem[st.sa_idx[3:0]] <= st.key;
            end
            if (mc_we) begin
                mc_mem[mc_group(st.sa_idx)] <= st.mc_fwd;
            end
            static_rdq <= static_mem[st.sa_idx[3:0]];
            mc_rdq <= mc_mem[mc_group(st.sa_idx)];
            mc_lookup_ports <= mc_exists(mc_lookup_addr) ?
                               mc_mem[mc_group(mc_lookup_addr)] : 3'h0;
            static_lookup_key <= static_mem[static_lookup_idx];
        end
    end

    // VLAN memory: contents are left to software to initialise
    always_ff @(posedge aclk) begin
        if (vlan_we) begin
            vlan_mem[st.v_idx] <= st.ve;
        end
        vlan_rdq <= vlan_mem[st.v_idx];
        vlan_lookup_entry <= vlan_mem[vlan_lookup_id];
    end

    // Lookup qualifier registered on the same edge as the read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lk_en_q <= 1'b0;
        end else begin
            lk_en_q <= vlan_mode_en;
        end
    end

    // Hit only in 802.1Q mode and on a valid entry
    assign vlan_lookup_hit = lk_en_q && vlan_lookup_entry.valid;
    assign vlan_use_members = vlan_lookup_hit && vlan_lookup_entry.fwd_option;
endmodule
`default_nettype wire

// *** stia_monitor.sv ***
// Port-level checker for the switch table access block.
// Assumes binding to the top module; all ports share aclk.
`timescale 1ns/1ps
`default_nettype none
`include "stia_defines.svh"
module stia_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awready,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic vlan_mode_en,
    input wire stia_pkg::stia_vlan_entry_t vlan_lookup_entry,
    input wire logic vlan_lookup_hit,
    input wire logic vlan_use_members,
    input wire logic [5:0] mc_lookup_addr,
    input wire logic [2:0] mc_lookup_ports
);
    import stia_pkg::*;
    logic [11:0] rd_addr;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Address of the read now being answered
    always_ff @(posedge aclk) begin
        if (arvalid && arready) begin
            rd_addr <= araddr;
        end
    end

    property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_w_block; bvalid |-> !awready && !wready; endproperty
    a_w_block: assert property (p_w_block) else $error("write taken early");
    property p_r_ans; arvalid && arready |=> rvalid; endproperty
    a_r_ans: assert property (p_r_ans) else $error("read not answered");
    property p_mc_out; mc_lookup_addr >= 6'h30 |=> mc_lookup_ports == 3'h0; endproperty
    a_mc_out: assert property (p_mc_out) else $error("ports on unused index");
    property p_hit_off; !vlan_mode_en |=> !vlan_lookup_hit; endproperty
    a_hit_off: assert property (p_hit_off) else $error("hit while disabled");
    property p_hit_on; vlan_mode_en |=> vlan_lookup_hit == vlan_lookup_entry.valid; endproperty
    a_hit_on: assert property (p_hit_on) else $error("hit not valid flag");
    property p_members; vlan_use_members |-> vlan_lookup_hit && vlan_lookup_entry.fwd_option;
    endproperty
    a_members: assert property (p_members) else $error("members without option");
    property p_mc_ro; rvalid && rd_addr == `STIA_MC_DATA_OFS |-> rdata[29:3] == 27'h0; endproperty
    a_mc_ro: assert property (p_mc_ro) else $error("forward word bits set");
    property p_key_ro; rvalid && rd_addr == `STIA_KEY_HI_OFS |-> rdata[31:23] == 9'h0; endproperty
    a_key_ro: assert property (p_key_ro) else $error("key word top bits set");
    property p_bad_rd; rvalid && rresp == `STIA_RESP_SLVERR |-> rdata == 32'h0; endproperty
    a_bad_rd: assert property (p_bad_rd) else $error("error read data");
    property p_rst; disable iff (1'h0) !aresetn |=> !bvalid && !rvalid; endproperty
    a_rst: assert property (p_rst) else $error("answer during reset");

    // Main scenarios reached
    c_slverr: cover property (rvalid && rresp == `STIA_RESP_SLVERR);
    c_members: cover property (vlan_use_members);
    c_mc: cover property (mc_lookup_ports != 3'h0);
endmodule
bind stia_switch_table_indirect_access stia_monitor mon_u (.*);
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the switch table access block.
// Assumes package, defines header, design and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "stia_defines.svh"
module tb;
    import stia_pkg::*;
    logic aclk, awready, wready, bvalid, arready, rvalid, vlan_lookup_hit, vlan_use_members;
    logic aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, vlan_mode_en = 1'h0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0, vlan_lookup_id = 12'h0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'hF, static_lookup_idx = 4'h0;
    logic [5:0] mc_lookup_addr = 6'h0;
    logic [2:0] mc_lookup_ports;
    logic [1:0] bresp, rresp, rr;
    stia_vlan_entry_t vlan_lookup_entry;
    stia_static_key_t static_lookup_key;
    int num_errors, total_checks;

    stia_switch_table_indirect_access dut_u (.*);

    // 100 MHz clock
    initial begin
        aclk = 1'h0;
        forever #5 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic end_sim;
        if (num_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One bus write; address and data offered together
    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 50 && !bvalid; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end
        bready <= 1'h0;
        check(32'(bvalid), 32'h1);
        check(32'(bresp), 32'(e));
    endtask

    // One bus read into rd and rr
    task automatic bus_rd(input logic [11:0] a);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 50 && !rvalid; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end
        rd = rdata;
        rr = rresp;
        rready <= 1'h0;
        check(32'(rvalid), 32'h1);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        bus_rd(a);
        check(rd, e);
    endtask

    // Wait for a self-clearing bit to drop
    task automatic poll(input logic [11:0] a, input int b);
        int n;
        for (n = 0; n < 20; n++) begin
            bus_rd(a);
            if (!rd[b]) break;
        end
        check(32'(rd[b]), 32'h0);
    endtask

    task automatic t_regs;
        rd_chk(`STIA_KEY_LO_OFS, 32'h0);
        rd_chk(`STIA_MC_DATA_OFS, 32'h0);
        bus_wr(`STIA_KEY_HI_OFS, 32'hFFFFFFFF, 2'h0);
        rd_chk(`STIA_KEY_HI_OFS, 32'h007FFFFF);
        bus_wr(`STIA_KEY_LO_OFS, 32'hA5C31E96, 2'h0);
        rd_chk(`STIA_KEY_LO_OFS, 32'hA5C31E96);
        wstrb <= 4'h3;
        bus_wr(`STIA_KEY_LO_OFS, 32'h0, 2'h0);
        wstrb <= 4'hF;
        rd_chk(`STIA_KEY_LO_OFS, 32'hA5C30000);
        bus_wr(`STIA_MC_DATA_OFS, 32'hFFFFFFFF, 2'h0);
        rd_chk(`STIA_MC_DATA_OFS, 32'hC0000007);
        bus_wr(12'h500, 32'h1, `STIA_RESP_SLVERR);
        rd_chk(12'h500, 32'h0);
        check(32'(rr), 32'(`STIA_RESP_SLVERR));
    endtask

    // Static entry 15 written, looked up, then read back over clobbered staging
    task automatic t_static;
        bus_wr(`STIA_KEY_HI_OFS, 32'h00550ABC, 2'h0);
        bus_wr(`STIA_KEY_LO_OFS, 32'h12345678, 2'h0);
        bus_wr(`STIA_SA_CTRL_OFS, 32'h800F, 2'h0);
        poll(`STIA_SA_CTRL_OFS, `STIA_SA_GO_BIT);
        static_lookup_idx <= 4'hF;
        repeat (2) @(posedge aclk);
        check(32'(static_lookup_key.filter_group_id), 32'h55);
        check(32'(static_lookup_key.mac_hi), 32'h0ABC);
        check(static_lookup_key.mac_lo, 32'h12345678);
        bus_wr(`STIA_KEY_HI_OFS, 32'h0, 2'h0);
        bus_wr(`STIA_KEY_LO_OFS, 32'h0, 2'h0);
        bus_wr(`STIA_SA_CTRL_OFS, 32'h820F, 2'h0);
        poll(`STIA_SA_CTRL_OFS, `STIA_SA_GO_BIT);
        rd_chk(`STIA_KEY_HI_OFS, 32'h00550ABC);
        rd_chk(`STIA_KEY_LO_OFS, 32'h12345678);
    endtask

    // One write per group, a ninth to unused index 50, then every index looked up
    task automatic t_mcast;
        int g;
        for (g = 0; g < 9; g++) begin
            bus_wr(`STIA_MC_DATA_OFS, 32'h80000000 | 32'(g % 7 + 1), 2'h0);
            bus_wr(`STIA_SA_CTRL_OFS, 32'h8100 | 32'(g * 6 + g % 6), 2'h0);
            poll(`STIA_SA_CTRL_OFS, `STIA_SA_GO_BIT);
        end
        for (g = 0; g < 64; g++) begin
            mc_lookup_addr <= 6'(g);
            repeat (2) @(posedge aclk);
            check(32'(mc_lookup_ports), g < 48 ? 32'((g / 6) % 7 + 1) : 32'h0);
        end
        bus_wr(`STIA_MC_DATA_OFS, 32'h40000000, 2'h0);
        bus_wr(`STIA_SA_CTRL_OFS, 32'h832F, 2'h0);
        poll(`STIA_SA_CTRL_OFS, `STIA_SA_GO_BIT);
        rd_chk(`STIA_MC_DATA_OFS, 32'h40000001);
    endtask

    task automatic vlan_wr(input logic [11:0] i, input logic [31:0] e0, input logic [31:0] e1);
        bus_wr(`STIA_V_E0_OFS, e0, 2'h0);
        bus_wr(`STIA_V_E1_OFS, e1, 2'h0);
        bus_wr(`STIA_V_E2_OFS, ~e1, 2'h0);
        bus_wr(`STIA_V_IDX_OFS, 32'(i), 2'h0);
        bus_wr(`STIA_V_CTRL_OFS, 32'h80, 2'h0);
        poll(`STIA_V_CTRL_OFS, `STIA_V_START_BIT);
    endtask

    // Two entries at the index ends looked up, the one at index 0xFFF read back
    task automatic t_vlan;
        vlan_wr(12'hFFF, 32'h0001D355, 32'hFFFFFFFD);
        vlan_wr(12'h000, 32'h00010000, 32'h2);
        vlan_lookup_id <= 12'hFFF;
        vlan_mode_en <= 1'h1;
        repeat (2) @(posedge aclk);
        check(32'(vlan_lookup_entry), 32'({5'h1D, 3'h3, 7'h55, 3'h5, 3'h2}));
        check(32'(vlan_use_members), 32'h1);
        vlan_lookup_id <= 12'h000;
        repeat (2) @(posedge aclk);
        check(32'(vlan_lookup_entry), 32'({5'h10, 3'h0, 7'h0, 3'h2, 3'h5}));
        check(32'({vlan_lookup_hit, vlan_use_members}), 32'h2);
        vlan_mode_en <= 1'h0;
        repeat (2) @(posedge aclk);
        check(32'(vlan_lookup_hit), 32'h0);
        bus_wr(`STIA_V_E0_OFS, 32'h0, 2'h0);
        bus_wr(`STIA_V_E1_OFS, 32'h0, 2'h0);
        bus_wr(`STIA_V_E2_OFS, 32'h0, 2'h0);
        bus_wr(`STIA_V_IDX_OFS, 32'hFFF, 2'h0);
        bus_wr(`STIA_V_CTRL_OFS, 32'h81, 2'h0);
        poll(`STIA_V_CTRL_OFS, `STIA_V_START_BIT);
        rd_chk(`STIA_V_E0_OFS, 32'h0001D355);
        rd_chk(`STIA_V_E1_OFS, 32'h5);
        rd_chk(`STIA_V_E2_OFS, 32'h2);
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs;
        t_static;
        t_mcast;
        t_vlan;
        end_sim;
    end

    // Hang guard
    initial begin
        #300000;
        num_errors++;
        end_sim;
    end
endmodule
`default_nettype wire
